// >>> giu_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches the top ports: answer timing and refused accesses reading zero
module giu_chk #(
  parameter int          NUM_SRC   = 256,
  parameter int          NUM_CORES = 4,
  parameter logic [31:0] REVISION  = 32'h0000_0000
) (
  // clock, reset, enable
  input wire logic        CLOCK,
  input wire logic        ARST_N,
  input wire logic        CE,
  // base register fields
  input wire logic [14:0] UNIT_BASE_FIELD,
  input wire logic        UNIT_ENABLE_BIT,
  // request and answer
  input wire logic        REQ_VALID,
  input wire logic        REQ_WRITE,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [3:0]  REQ_PROC,
  input wire logic        RSP_VALID,
  input wire logic [31:0] RSP_RDATA,
  // processor pins
  input wire logic [15:0] VP_IRQ,
  input wire logic [15:0] VP_NMI,
  input wire logic [15:0] VP_YIELD
);
  // config word rebuilt from the parameters, not from the design
  localparam logic [31:0] CFG_EXP = (32'(NUM_SRC / 8 - 1) << 16) | 32'(NUM_CORES * 4 - 1);
  logic        take;    // request taken at this edge
  logic        hit_rd;  // load that must be served
  logic [15:0] off_cnt; // cycles spent disabled, saturating
  assign take   = REQ_VALID && CE;
  assign hit_rd = take && !REQ_WRITE && UNIT_ENABLE_BIT && REQ_ADDR[31:17] == UNIT_BASE_FIELD
                  && REQ_PROC[1:0] != 2'h3 && 32'(REQ_PROC) < NUM_CORES * 4;
  // pins only settle after a whole sweep, so wait that long before judging
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) off_cnt <= 16'h0000;
    else if (UNIT_ENABLE_BIT) off_cnt <= 16'h0000;
    else if (off_cnt != 16'hffff) off_cnt <= off_cnt + 16'h0001;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  a_rsp_two_after: assert property (take |-> ##2 RSP_VALID)
    else $error("answer not two cycles after request");
  a_rsp_has_cause: assert property (RSP_VALID |-> $past(take, 2))
    else $error("answer without request");
  a_store_reads_zero: assert property (take && REQ_WRITE |-> ##2 RSP_RDATA == 32'h0)
    else $error("store answered with data");
  a_foreign_base_zero: assert property (take && REQ_ADDR[31:17] != UNIT_BASE_FIELD |-> ##2 RSP_RDATA == 32'h0)
    else $error("foreign address returned data");
  a_disabled_reads_zero: assert property (take && !UNIT_ENABLE_BIT |-> ##2 RSP_RDATA == 32'h0)
    else $error("disabled unit returned data");
  a_reserved_proc_zero: assert property (take && REQ_PROC[1:0] == 2'h3 |-> ##2 RSP_RDATA == 32'h0)
    else $error("reserved requester returned data");
  a_config_word: assert property (hit_rd && REQ_ADDR[16:0] == 17'h00000 |-> ##2 RSP_RDATA == CFG_EXP)
    else $error("config word wrong");
  a_revision_word: assert property (hit_rd && REQ_ADDR[16:0] == 17'h00020 |-> ##2 RSP_RDATA == REVISION)
    else $error("revision word wrong");
  a_user_alias_only: assert property (hit_rd && REQ_ADDR[16] && REQ_ADDR[15:0] != 16'h0010
    && REQ_ADDR[15:0] != 16'h0014 |-> ##2 RSP_RDATA == 32'h0) else $error("user window leaks a register");
  a_off_pins_low: assert property (off_cnt > 16'(NUM_SRC + 4) |-> (VP_IRQ | VP_NMI | VP_YIELD) == 16'h0)
    else $error("pins active while disabled");
endmodule : giu_chk
bind giu_top giu_chk #(.NUM_SRC(NUM_SRC), .NUM_CORES(NUM_CORES), .REVISION(REVISION)) u_chk (
  .CLOCK(CLOCK), .ARST_N(ARST_N), .CE(CE), .UNIT_BASE_FIELD(UNIT_BASE_FIELD),
  .UNIT_ENABLE_BIT(UNIT_ENABLE_BIT), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
  .REQ_PROC(REQ_PROC), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .VP_IRQ(VP_IRQ), .VP_NMI(VP_NMI),
  .VP_YIELD(VP_YIELD));
`default_nettype wire

// >>> giu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// processor side: issues one uncached kernel-mode word access at a time
module giu_cpu_model (
  // clock and the base this processor believes in
  input  wire logic        clk,
  input  wire logic [14:0] base,
  // request
  output logic             req_valid,
  output logic             req_write,
  output logic [31:0]      req_addr,
  output logic [3:0]       req_proc,
  output logic [31:0]      req_wdata,
  // answer
  input  wire logic        rsp_valid,
  input  wire logic [31:0] rsp_rdata
);
  // idle at time zero
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = 32'h0000_0000;
    req_proc  = 4'h0;
    req_wdata = 32'h0000_0000;
  end
  // only privileged accesses are issued from here
  task automatic access(input logic wr, input logic [3:0] proc, input logic [16:0] off,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = {base, off};
    req_proc  = proc;
    req_wdata = wd;
    @(posedge clk);
    #1;
    // released lines are inverted so a stale value never passes for a request
    req_valid = 1'b0;
    req_write = ~wr;
    req_addr  = ~req_addr;
    req_proc  = ~proc;
    req_wdata = ~wd;
    // the answer register stands between the second and third edge after the request
    @(posedge clk);
    #1;
    ok = rsp_valid;
    rd = rsp_rdata;
  endtask : access
endmodule : giu_cpu_model
`default_nettype wire

// >>> giu_map_mem.sv
`timescale 1ns/1ps
`default_nettype none
// routing map store: one write port, two registered read ports
module giu_map_mem #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 256
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // memory port
  giu_mem_if.mem    port
);
  logic [WIDTH-1:0] store [DEPTH]; // array itself holds no reset

  // write port
  always_ff @(posedge clk) begin
    if (port.ce && port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  // both read ports come out of a register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port.a_data <= '0;
      port.b_data <= '0;
    end else if (port.ce) begin
      port.a_data <= store[port.a_addr];
      port.b_data <= store[port.b_addr];
    end
  end
endmodule : giu_map_mem
`default_nettype wire

// >>> giu_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
// carrier between the decoder and the map memory
interface giu_mem_if #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 256,
  parameter int AW    = 8
);
  logic             ce;      // clock enable
  logic             wr_en;   // write strobe
  logic [AW-1:0]    wr_addr; // write index
  logic [WIDTH-1:0] wr_data; // write word
  logic [AW-1:0]    a_addr;  // bus read index
  logic [WIDTH-1:0] a_data;  // bus read word, registered
  logic [AW-1:0]    b_addr;  // scanner read index
  logic [WIDTH-1:0] b_data;  // scanner read word, registered
  modport user (output ce, wr_en, wr_addr, wr_data, a_addr, b_addr, input a_data, b_data);
  modport mem  (input ce, wr_en, wr_addr, wr_data, a_addr, b_addr, output a_data, b_data);
endinterface : giu_mem_if
`default_nettype wire

// >>> giu_pkg.sv
// How it works
// - four slots per core, fourth slot reserved
// - four cores, twelve processors, own local registers
// - offsets below 32 KB decode to shared section
// - local section indexed by requesting processor number
// - other section indexed by other-processor addressing register
// - user window aliases are read-only, writes ignored
// - user window holds only counter low/high words
// - base is 15-bit field, address adds offsets
// - shared register offsets 0x000/0x010/0x014/0x020/0x100
// - up to 256 sources, scalable source/processor counts
// - level high/low, rising, falling or dual edge
// - steer any source anywhere; processors interrupt each other
// - unit disabled until enable bit set
package giu_pkg;
  // bus geometry
  localparam int          ADDR_W        = 32;
  localparam int          DATA_W        = 32;
  localparam int          PROC_W        = 4;
  localparam int          BASE_W        = 15;
  localparam int          OFF_W         = 17;
  localparam int          SLOTS         = 16;
  localparam int          SLOTS_PER_CORE = 4;
  localparam logic [1:0]  VP_PER_CORE   = 2'h3;
  // section offsets and sizes inside the unit
  localparam logic [16:0] SHARED_BASE   = 17'h00000;
  localparam logic [16:0] LOCAL_BASE    = 17'h08000;
  localparam logic [16:0] OTHER_BASE    = 17'h0c000;
  localparam logic [16:0] USER_BASE     = 17'h10000;
  localparam logic [16:0] SHARED_SIZE   = 17'h08000;
  localparam logic [16:0] LOCAL_SIZE    = 17'h04000;
  localparam logic [16:0] USER_SIZE     = 17'h10000;
  // shared register offsets
  localparam logic [16:0] REG_CONFIG    = 17'h00000;
  localparam logic [16:0] REG_CNT_LO    = 17'h00010;
  localparam logic [16:0] REG_CNT_HI    = 17'h00014;
  localparam logic [16:0] REG_REVISION  = 17'h00020;
  localparam logic [16:0] REG_POL       = 17'h00100;
  localparam logic [16:0] REG_TRIG      = 17'h00180;
  localparam logic [16:0] REG_DUAL      = 17'h00200;
  localparam logic [16:0] REG_EDGE      = 17'h00280;
  localparam logic [16:0] REG_MAP       = 17'h02000;
  localparam int          MAP_SHIFT     = 5;
  // local-section register offsets
  localparam logic [16:0] REG_SWINT     = 17'h00040;
  localparam logic [16:0] REG_OTHER     = 17'h00080;
  // field positions
  localparam int          CFG_SLICE_LSB = 16;
  localparam int          CFG_PROC_LSB  = 0;
  localparam int          MAP_VP_LSB    = 0;
  localparam int          MAP_PIN_LSB   = 8;
  localparam int          MAP_W         = 6;
  // reset values
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam logic [3:0]  OTHER_RESET   = 4'h0;
  // output pin selection in a map register
  typedef enum logic [1:0] {
    PIN_IRQ   = 2'h0,
    PIN_NMI   = 2'h1,
    PIN_YIELD = 2'h2,
    PIN_NONE  = 2'h3
  } giu_pin_e;
endpackage : giu_pkg

// >>> giu_top.sv
`timescale 1ns/1ps
`default_nettype none
// address decoder and register front end of the global interrupt unit
module giu_top #(
  parameter int          NUM_SRC   = 256,          // multiple of 32
  parameter int          NUM_CORES = 4,
  parameter logic [31:0] REVISION  = 32'h0000_0100 // arbitrary value
) (
  // clock, reset, enable
  input  wire logic                      CLOCK,
  input  wire logic                      ARST_N,
  input  wire logic                      CE,
  // coherence base register fields
  input  wire logic [giu_pkg::BASE_W-1:0] UNIT_BASE_FIELD,
  input  wire logic                      UNIT_ENABLE_BIT,
  // load/store request
  input  wire logic                      REQ_VALID,
  input  wire logic                      REQ_WRITE,
  input  wire logic [giu_pkg::ADDR_W-1:0] REQ_ADDR,
  input  wire logic [giu_pkg::PROC_W-1:0] REQ_PROC,
  input  wire logic [giu_pkg::DATA_W-1:0] REQ_WDATA,
  // answer
  output logic                           RSP_VALID,
  output logic [giu_pkg::DATA_W-1:0]     RSP_RDATA,
  // external sources
  input  wire logic [NUM_SRC-1:0]        SRC_IN,
  // per-processor interrupt inputs
  output logic [giu_pkg::SLOTS-1:0]      VP_IRQ,
  output logic [giu_pkg::SLOTS-1:0]      VP_NMI,
  output logic [giu_pkg::SLOTS-1:0]      VP_YIELD
);
  import giu_pkg::*;

  localparam int WORDS = NUM_SRC / 32;    // 32 sources per word
  localparam int SW    = $clog2(NUM_SRC); // source index width
  localparam logic [SW-1:0] LAST_SRC = SW'(NUM_SRC - 1);

  // slot is a present processor
  function automatic logic proc_ok(input logic [PROC_W-1:0] p);
    return (p[1:0] < VP_PER_CORE) && (32'(p[3:2]) < NUM_CORES);
  endfunction : proc_ok

  // offset falls inside a window
  function automatic logic in_win(input logic [16:0] o, input logic [16:0] lo, input logic [16:0] n);
    return (o >= lo) && ((o - lo) < n);
  endfunction : in_win

  // word index inside a 32-bit bank
  function automatic int bank_idx(input logic [16:0] o, input logic [16:0] lo);
    return int'((o - lo) >> 2);
  endfunction : bank_idx

  // request decode
  logic             hit;       // address lands in the enabled unit from a present requester
  logic [16:0]      off;       // offset within the unit
  logic             is_shared; // shared section
  logic             is_local;  // own local section
  logic             is_other;  // other-processor section
  logic             is_user;   // user-visible window
  logic [PROC_W-1:0] tgt;      // processor whose local set is touched
  logic             tgt_ok;    // both requester and target present
  logic [16:0]      loc_off;   // offset within a local set
  logic             wr;        // accepted write
  logic             map_hit;   // map register addressed
  logic [SW-1:0]    map_idx;   // map register index
  logic [PROC_W-1:0] other_addr [SLOTS]; // other-processor addressing registers
  logic [SLOTS-1:0] swint;     // software interrupt per processor

  always_comb begin
    // a reserved requester reaches nothing in any section, so it reads zero and its stores drop
    hit       = REQ_VALID && UNIT_ENABLE_BIT && (REQ_ADDR[31:17] == UNIT_BASE_FIELD)
                && proc_ok(REQ_PROC);
    off       = REQ_ADDR[16:0];
    is_shared = in_win(off, SHARED_BASE, SHARED_SIZE);
    is_local  = in_win(off, LOCAL_BASE, LOCAL_SIZE);
    is_other  = in_win(off, OTHER_BASE, LOCAL_SIZE);
    is_user   = in_win(off, USER_BASE, USER_SIZE);
    // the requester's own number selects its set in the local section; the other section uses its other_addr entry
    tgt       = is_other ? other_addr[REQ_PROC] : REQ_PROC;
    tgt_ok    = proc_ok(REQ_PROC) && proc_ok(tgt);
    loc_off   = off - (is_other ? OTHER_BASE : LOCAL_BASE);
    wr        = hit && REQ_WRITE && CE;
    map_hit   = is_shared && in_win(off, REG_MAP, 17'(NUM_SRC << MAP_SHIFT)) && (off[4:0] == 5'h00);
    map_idx   = SW'((off - REG_MAP) >> MAP_SHIFT);
  end

  // source configuration banks
  logic [NUM_SRC-1:0] pol;  // high level / rising edge
  logic [NUM_SRC-1:0] trig; // edge when set
  logic [NUM_SRC-1:0] dual; // both edges when set

  // trigger configuration writes
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pol  <= '0;
      trig <= '0;
      dual <= '0;
    end else if (wr && is_shared) begin
      if (in_win(off, REG_POL, 17'(WORDS * 4))) begin
        pol[bank_idx(off, REG_POL)*32 +: 32] <= REQ_WDATA;
      end
      if (in_win(off, REG_TRIG, 17'(WORDS * 4))) begin
        trig[bank_idx(off, REG_TRIG)*32 +: 32] <= REQ_WDATA;
      end
      if (in_win(off, REG_DUAL, 17'(WORDS * 4))) begin
        dual[bank_idx(off, REG_DUAL)*32 +: 32] <= REQ_WDATA;
      end
    end
  end

  // source synchronisers: pins are asynchronous to CLOCK
  logic [NUM_SRC-1:0] src_s1; // first stage, read only by src_s2
  logic [NUM_SRC-1:0] src_s2; // safe level
  logic [NUM_SRC-1:0] src_s3; // previous level for edges
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      src_s1 <= '0;
      src_s2 <= '0;
      src_s3 <= '0;
    end else if (CE) begin
      src_s1 <= SRC_IN;
      src_s2 <= src_s1;
      src_s3 <= src_s2;
    end
  end

  // trigger detection
  logic [NUM_SRC-1:0] edge_ev;   // edge event this cycle
  logic [NUM_SRC-1:0] edge_pend; // sticky edge pending
  logic [NUM_SRC-1:0] edge_clr;  // write-one-to-clear mask
  logic [NUM_SRC-1:0] pend;      // source asserted
  always_comb begin
    edge_ev  = trig & ((dual & (src_s2 ^ src_s3)) | (~dual & ~(src_s2 ^ pol) & (src_s2 ^ src_s3)));
    pend     = (~trig & ~(src_s2 ^ pol)) | edge_pend;
    edge_clr = '0;
    if (wr && is_shared && in_win(off, REG_EDGE, 17'(WORDS * 4))) begin
      edge_clr[bank_idx(off, REG_EDGE)*32 +: 32] = REQ_WDATA;
    end
  end

  // sticky edges; a new edge wins over a clear in the same cycle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      edge_pend <= '0;
    end else if (CE) begin
      edge_pend <= (edge_pend & ~edge_clr) | edge_ev;
    end
  end

  // shared counter, runs only while the unit is enabled
  logic [63:0] counter;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      counter <= '0;
    end else if (wr && is_shared && off == REG_CNT_LO) begin
      counter[31:0] <= REQ_WDATA;
    end else if (wr && is_shared && off == REG_CNT_HI) begin
      counter[63:32] <= REQ_WDATA;
    end else if (CE && UNIT_ENABLE_BIT) begin
      counter <= counter + 64'h1;
    end
  end

  // per-processor local registers; reserved targets drop writes
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      other_addr <= '{default: OTHER_RESET};
      swint      <= '0;
    end else if (wr && (is_local || is_other) && tgt_ok) begin
      if (loc_off == REG_OTHER) begin
        other_addr[tgt] <= REQ_WDATA[PROC_W-1:0];
      end
      if (loc_off == REG_SWINT) begin
        swint[tgt] <= REQ_WDATA[0];
      end
    end
  end

  // map store, one word per source
  giu_mem_if #(.WIDTH(MAP_W), .DEPTH(NUM_SRC), .AW(SW)) mif ();
  giu_map_mem #(.WIDTH(MAP_W), .DEPTH(NUM_SRC)) u_map (
    .clk    (CLOCK),
    .arst_n (ARST_N),
    .port   (mif.mem)
  );
  logic [NUM_SRC-1:0] map_set; // map written since reset; unwritten ones route nowhere
  logic [SW-1:0]      scan;    // scanner read index
  logic [SW-1:0]      scan_q;  // index of word now on b_data
  logic               scan_live; // b_data valid
  always_comb begin
    mif.ce      = CE;
    mif.wr_en   = wr && map_hit;
    mif.wr_addr = map_idx;
    mif.wr_data = {REQ_WDATA[MAP_PIN_LSB +: 2], REQ_WDATA[MAP_VP_LSB +: PROC_W]};
    mif.a_addr  = map_idx;
    mif.b_addr  = scan;
  end

  // written flags for map words
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      map_set <= '0;
    end else if (wr && map_hit) begin
      map_set[map_idx] <= 1'b1;
    end
  end

  // scanner walks every source; one sweep costs NUM_SRC cycles of routing latency,
  // traded for a single memory instead of a flop per map word
  logic [SLOTS-1:0] acc_irq, acc_nmi, acc_yld; // sweep accumulators
  logic [SLOTS-1:0] hit_irq, hit_nmi, hit_yld; // this word's contribution
  logic [SLOTS-1:0] hold_irq;                  // last sweep's pin routing
  giu_pin_e         scan_pin;
  always_comb begin
    scan_pin = giu_pin_e'(mif.b_data[5:4]);
    hit_irq  = '0;
    hit_nmi  = '0;
    hit_yld  = '0;
    if (scan_live && pend[scan_q] && map_set[scan_q] && proc_ok(mif.b_data[3:0])) begin
      case (scan_pin)
        PIN_IRQ:   hit_irq[mif.b_data[3:0]] = 1'b1;
        PIN_NMI:   hit_nmi[mif.b_data[3:0]] = 1'b1;
        PIN_YIELD: hit_yld[mif.b_data[3:0]] = 1'b1;
        default:   hit_irq = '0; // unrouted
      endcase
    end
  end

  // sweep bookkeeping and output latching
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      scan      <= '0;
      scan_q    <= '0;
      scan_live <= 1'b0;
      acc_irq   <= '0;
      acc_nmi   <= '0;
      acc_yld   <= '0;
      hold_irq  <= '0;
      VP_NMI    <= '0;
      VP_YIELD  <= '0;
    end else if (CE) begin
      scan      <= (scan == LAST_SRC) ? '0 : scan + SW'(1);
      scan_q    <= scan;
      scan_live <= 1'b1;
      if (scan_live && scan_q == LAST_SRC) begin
        hold_irq <= UNIT_ENABLE_BIT ? (acc_irq | hit_irq) : '0;
        VP_NMI   <= UNIT_ENABLE_BIT ? (acc_nmi | hit_nmi) : '0;
        VP_YIELD <= UNIT_ENABLE_BIT ? (acc_yld | hit_yld) : '0;
        acc_irq  <= '0;
        acc_nmi  <= '0;
        acc_yld  <= '0;
      end else begin
        acc_irq <= acc_irq | hit_irq;
        acc_nmi <= acc_nmi | hit_nmi;
        acc_yld <= acc_yld | hit_yld;
      end
    end
  end

  // interrupt pin: routed sources plus software interrupts
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      VP_IRQ <= '0;
    end else if (CE) begin
      VP_IRQ <= UNIT_ENABLE_BIT ? (hold_irq | swint) : '0;
    end
  end

  // read mux for everything not in the map memory
  logic [31:0] rd_direct;
  always_comb begin
    rd_direct = ZERO_WORD;
    if (hit && is_shared) begin
      if (off == REG_CONFIG) begin
        rd_direct[CFG_SLICE_LSB +: 8] = 8'(NUM_SRC / 8 - 1);
        rd_direct[CFG_PROC_LSB +: 4]  = 4'(NUM_CORES * SLOTS_PER_CORE - 1);
      end else if (off == REG_CNT_LO) begin
        rd_direct = counter[31:0];
      end else if (off == REG_CNT_HI) begin
        rd_direct = counter[63:32];
      end else if (off == REG_REVISION) begin
        rd_direct = REVISION;
      end else if (in_win(off, REG_POL, 17'(WORDS * 4))) begin
        rd_direct = pol[bank_idx(off, REG_POL)*32 +: 32];
      end else if (in_win(off, REG_TRIG, 17'(WORDS * 4))) begin
        rd_direct = trig[bank_idx(off, REG_TRIG)*32 +: 32];
      end else if (in_win(off, REG_DUAL, 17'(WORDS * 4))) begin
        rd_direct = dual[bank_idx(off, REG_DUAL)*32 +: 32];
      end else if (in_win(off, REG_EDGE, 17'(WORDS * 4))) begin
        rd_direct = edge_pend[bank_idx(off, REG_EDGE)*32 +: 32];
      end
    end else if (hit && (is_local || is_other) && tgt_ok) begin
      if (loc_off == REG_OTHER) begin
        rd_direct[PROC_W-1:0] = other_addr[tgt];
      end else if (loc_off == REG_SWINT) begin
        rd_direct[0] = swint[tgt];
      end
    end else if (hit && is_user) begin
      // only the counter is aliased; stores here change nothing
      if (off - USER_BASE == REG_CNT_LO) begin
        rd_direct = counter[31:0];
      end else if (off - USER_BASE == REG_CNT_HI) begin
        rd_direct = counter[63:32];
      end
    end
  end

  // answer pipeline: fixed two-edge latency, memory word joins in stage two
  logic        v1;  // request in flight
  logic        m1;  // answer comes from the map memory
  logic [31:0] d1;  // direct read data
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      v1        <= 1'b0;
      m1        <= 1'b0;
      d1        <= ZERO_WORD;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= ZERO_WORD;
    end else if (CE) begin
      v1        <= REQ_VALID;
      m1        <= hit && !REQ_WRITE && map_hit;
      d1        <= REQ_WRITE ? ZERO_WORD : rd_direct;
      RSP_VALID <= v1;
      RSP_RDATA <= m1 ? {22'h0, mif.a_data[5:4], 4'h0, mif.a_data[3:0]} : d1;
    end
  end
endmodule : giu_top
`default_nettype wire

// >>> giu_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
// register-level test of the decoder through a modelled processor
module giu_top_bench;
  import giu_pkg::*;
  localparam int          NSRC = 32;            // short sweep
  localparam logic [31:0] REV  = 32'h0000_0042; // arbitrary value
  logic              clock     = 1'b0;
  logic              arst_n    = 1'b0;
  logic              en        = 1'b1;
  logic              ce        = 1'b1;  // lowered once to prove the freeze
  logic              ok_u;              // answer flag of the user-window load
  logic [14:0]       unit_base = 15'h1abc;
  logic [14:0]       cpu_base  = 15'h1abc; // differs only in the foreign-base case
  logic [NSRC-1:0]   src_in    = '0;
  logic              req_valid, req_write, rsp_valid;
  logic [31:0]       req_addr, req_wdata, rsp_rdata, d;
  logic [3:0]        req_proc;
  logic [15:0]       vp_irq, vp_nmi, vp_yield;
  int                n_fail = 0;
  int                total_checks = 0;
  always #5 clock = ~clock;
  giu_top #(.NUM_SRC(NSRC), .NUM_CORES(4), .REVISION(REV)) DUT (
    .CLOCK(clock), .ARST_N(arst_n), .CE(ce), .UNIT_BASE_FIELD(unit_base), .UNIT_ENABLE_BIT(en),
    .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_PROC(req_proc),
    .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .SRC_IN(src_in),
    .VP_IRQ(vp_irq), .VP_NMI(vp_nmi), .VP_YIELD(vp_yield));
  giu_cpu_model cpu (
    .clk(clock), .base(cpu_base), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_proc(req_proc), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  // store: always answered, never with data
  task automatic wr(input logic [3:0] p, input logic [16:0] o, input logic [31:0] v);
    logic [31:0] r;
    logic        ok;
    cpu.access(1'b1, p, o, v, r, ok);
    `CHK(ok, 1'b1)
    `CHK(r, 32'h0)
  endtask : wr
  // load and compare
  task automatic rchk(input logic [3:0] p, input logic [16:0] o, input logic [31:0] e);
    logic ok;
    cpu.access(1'b0, p, o, 32'h0, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask : rchk
  // two routing sweeps plus margin: a change just after its scan waits a whole extra pass
  task automatic sweep();
    repeat (2 * NSRC + 8) @(posedge clock);
    #1;
  endtask : sweep
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // hang guard, well beyond the few hundred cycles the run needs
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clock);
    #1 arst_n = 1'b1;
    rchk(0, 17'h00000, 32'h0003_000f);
    rchk(4, 17'h00020, REV);
    wr(0, 17'h00100, 32'ha5a5_5a5a);
    rchk(1, 17'h00100, 32'ha5a5_5a5a);
    wr(0, 17'h07ffc, 32'hffff_ffff);
    rchk(0, 17'h07ffc, 32'h0);
    // counter words and their user-window aliases
    wr(0, 17'h00014, 32'h1234_5678);
    wr(0, 17'h00010, 32'h0);
    cpu.access(1'b0, 4'h2, 17'h10010, 32'h0, d, ok_u);
    `CHK(ok_u, 1'b1)
    `CHK(d < 32'h40, 1'b1)
    rchk(0, 17'h10014, 32'h1234_5678);
    wr(0, 17'h10014, 32'h0);
    rchk(0, 17'h00014, 32'h1234_5678);
    rchk(0, 17'h10020, 32'h0);
    // clock enable low freezes the counter; lowered only once the answer pipeline is idle
    wr(0, 17'h00010, 32'h0);
    @(posedge clock);
    #1 ce = 1'b0;
    repeat (20) @(posedge clock);
    #1 ce = 1'b1;
    rchk(0, 17'h00010, 32'h3);
    // reserved requesters see nothing
    for (int p = 3; p < 16; p += 4) rchk(4'(p), 17'h00000, 32'h0);
    // local and other sections
    wr(0, 17'h08080, 32'h5);
    rchk(0, 17'h08080, 32'h5);
    rchk(1, 17'h08080, 32'h0);
    wr(5, 17'h08080, 32'h9);
    rchk(0, 17'h0c080, 32'h9);
    wr(0, 17'h0c040, 32'h1);
    `CHK(vp_irq, 16'h0020)
    wr(0, 17'h0c040, 32'h0);
    `CHK(vp_irq, 16'h0000)
    wr(0, 17'h08080, 32'h7);
    rchk(0, 17'h0c080, 32'h0);
    cpu_base = 15'h0001;
    rchk(0, 17'h00000, 32'h0);
    cpu_base = unit_base;
    // src0 level high, src1 level low, src2 rising, src3 falling, src4 dual
    wr(0, 17'h00100, 32'h0000_0005);
    wr(0, 17'h00180, 32'h0000_001c);
    wr(0, 17'h00200, 32'h0000_0010);
    wr(0, 17'h02000, 32'h0000_0104);
    wr(0, 17'h02020, 32'h0000_0201);
    wr(0, 17'h00280, 32'hffff_ffff);
    sweep();
    `CHK(vp_yield, 16'h0002)
    `CHK(vp_nmi, 16'h0000)
    src_in = 32'h0000_001f;
    sweep();
    `CHK(vp_nmi, 16'h0010)
    `CHK(vp_yield, 16'h0000)
    rchk(0, 17'h00280, 32'h0000_0014);
    wr(0, 17'h00280, 32'h0000_001f);
    src_in = 32'h0;
    repeat (6) @(posedge clock);
    #1;
    rchk(0, 17'h00280, 32'h0000_0018);
    src_in = 32'h0000_0001;
    en = 1'b0;
    rchk(0, 17'h00000, 32'h0);
    sweep();
    `CHK(vp_yield, 16'h0000)
    `CHK(vp_nmi, 16'h0000)
    conclude();
  end
endmodule : giu_top_bench
`default_nettype wire
